// [hw/octbt_pkg.sv]
// Package for the octal bus transceiver with storage registers.
// Assumes one 250 MHz system clock; all pins are asynchronous to it.
package octbt_pkg;
    // ====================================================================
    // Sizes and reset values
    localparam int OCTBT_WIDTH = 8;
    localparam int OCTBT_SYNC_STAGES = 2;
    localparam logic [7:0] OCTBT_REG_RST = 8'h00;
    localparam logic [7:0] OCTBT_OUT_RST = 8'h00;
    localparam logic OCTBT_OE_N_RST = 1'b1;

    // ====================================================================
    // One bus side as driven by the device: data and active-low enable.
    typedef struct packed {
        logic [OCTBT_WIDTH-1:0] dout;
        logic oe_n;
    } octbt_drive_t;

    // Control pins after synchronisation.
    typedef struct packed {
        logic a_to_b_drive_enable;
        logic b_to_a_drive_enable_n;
        logic b_side_source_select;
        logic a_side_source_select;
    } octbt_ctrl_t;
endpackage

// [hw/octbt_top.sv]
// Octal bus transceiver with one storage register per direction.
// Assumes every pin input is asynchronous to ref_clk; a testbench resolves
// the bus wires from the data outputs and the active-low drive enables.
// Functional notes
// R01 - Eight bits pass between A and B buses; separate A and B registers.
// R02 - Select low drives live opposite-bus data; high drives stored data.
// R03 - Rising capture clock edge loads its bus into its register, always.
// R04 - B drives only with A-to-B enable high; A only with enable_n low.
// R05 - Both live, both enabled: each bus output reinforces its own level.
// R06 - Enables low, A select low: A bus gets live B data.
// R07 - Enables low, A select high: A bus gets inverted B register.
// R08 - Enables high, B select low: B bus gets inverted live A data.
// R09 - Enables high, B select high: B bus gets A register.
// R10 - A-to-B high, B-to-A low, selects high: both buses get stored data.
// R11 - B fed live from A with both edges: A register loads A data, B register loads inverted A data.
// R12 - A fed live from B with both edges: both registers load B data.
// R13 - Live select: outside may pulse both clocks, allowing path delays.
// R14 - Stored select: outside must stagger the two capture edges.
// R15 - A register changes only on its capture clock rising edge.
// R16 - After power-up both buses stay undriven until enabled.
`timescale 1ns/1ps
module octbt_top
    import octbt_pkg::*;
#(
    parameter int WIDTH = OCTBT_WIDTH
)
(
    input wire logic ref_clk, // System clock, 250 MHz.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic [WIDTH-1:0] a_bus_in, // A bus pin levels.
    output logic [WIDTH-1:0] a_bus_out, // A bus drive data.
    output logic a_bus_oe_n, // A bus drive enable, low drives.
    input wire logic [WIDTH-1:0] b_bus_in, // B bus pin levels.
    output logic [WIDTH-1:0] b_bus_out, // B bus drive data.
    output logic b_bus_oe_n, // B bus drive enable, low drives.
    input wire logic a_to_b_drive_enable, // High lets B side drive.
    input wire logic b_to_a_drive_enable_n, // Low lets A side drive.
    input wire logic a_capture_clock, // Rising edge stores A bus.
    input wire logic b_capture_clock, // Rising edge stores B bus.
    input wire logic b_side_source_select, // High: B gets stored data.
    input wire logic a_side_source_select // High: A gets stored data.
);
    // ====================================================================
    // Elaboration check
    if (WIDTH != OCTBT_WIDTH)
    begin : g_bad_width
        $error("octbt_top: WIDTH must equal the package bus width");
    end

    // ====================================================================
    // Synchronisers
    octbt_ctrl_t ctrl_meta_ff, ctrl_ff;
    logic [WIDTH-1:0] a_meta_ff, a_live_ff, b_meta_ff, b_live_ff;
    logic [2:0] cka_ff, ckb_ff;
    logic [WIDTH-1:0] a_reg_ff, b_reg_ff;
    octbt_drive_t a_drv_ff, b_drv_ff;
    octbt_drive_t nxt_a_drv, nxt_b_drv;
    wire octbt_ctrl_t ctrl_pins = '{a_to_b_drive_enable,
        b_to_a_drive_enable_n, b_side_source_select, a_side_source_select};

    // Two flops on every data and control pin; only stage two feeds logic.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ctrl_meta_ff <= '{1'b0, 1'b1, 1'b0, 1'b0};
            ctrl_ff <= '{1'b0, 1'b1, 1'b0, 1'b0};
            a_meta_ff <= OCTBT_REG_RST;
            a_live_ff <= OCTBT_REG_RST;
            b_meta_ff <= OCTBT_REG_RST;
            b_live_ff <= OCTBT_REG_RST;
        end
        else
        begin
            ctrl_meta_ff <= ctrl_pins;
            ctrl_ff <= ctrl_meta_ff;
            a_meta_ff <= a_bus_in;
            a_live_ff <= a_meta_ff;
            b_meta_ff <= b_bus_in;
            b_live_ff <= b_meta_ff;
        end
    end

    // Capture clocks: two sync stages plus one history stage for edges.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cka_ff <= 3'h0;
            ckb_ff <= 3'h0;
        end
        else
        begin
            cka_ff <= {cka_ff[1:0], a_capture_clock};
            ckb_ff <= {ckb_ff[1:0], b_capture_clock};
        end
    end

    // ====================================================================
    // Decode
    // Edges are seen on stages two and three, never on the metastable one.
    wire a_edge = cka_ff[1] & ~cka_ff[2];
    wire b_edge = ckb_ff[1] & ~ckb_ff[2];
    wire oe_ab = ctrl_ff.a_to_b_drive_enable;
    wire oe_ba_n = ctrl_ff.b_to_a_drive_enable_n;
    wire sel_b = ctrl_ff.b_side_source_select;
    wire sel_a = ctrl_ff.a_side_source_select;
    // Two enabled live paths would form a ring; instead each side holds.
    wire reinforce = oe_ab & ~oe_ba_n & ~sel_a & ~sel_b; // see R05
    // Stored B goes out inverted only in the A-only direction.
    wire [WIDTH-1:0] a_stored = oe_ab ? b_reg_ff : ~b_reg_ff; // see R07 R10
    wire [WIDTH-1:0] a_sel = sel_a ? a_stored : b_live_ff; // see R02 R06
    wire [WIDTH-1:0] b_sel = sel_b ? a_reg_ff : ~a_live_ff; // see R08 R09

    // Next drive values for both sides.
    always_comb
    begin
        nxt_a_drv.dout = reinforce ? a_live_ff : a_sel;
        nxt_a_drv.oe_n = oe_ba_n; // see R04
        nxt_b_drv.dout = reinforce ? b_live_ff : b_sel;
        nxt_b_drv.oe_n = ~oe_ab; // see R04
    end

    // ====================================================================
    // Storage registers
    // Loads ignore select and enable; sampling both sides on the same
    // cycle gives equal contents when A is fed from B, inverse contents when B is fed from A.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            a_reg_ff <= OCTBT_REG_RST;
            b_reg_ff <= OCTBT_REG_RST;
        end
        else
        begin
            if (a_edge)
                a_reg_ff <= a_live_ff; // see R03 R11 R15
            if (b_edge)
                b_reg_ff <= b_live_ff; // see R03 R12 R15
        end
    end

    // Output flops; reset leaves both buses undriven.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            a_drv_ff <= '{OCTBT_OUT_RST, OCTBT_OE_N_RST}; // see R16
            b_drv_ff <= '{OCTBT_OUT_RST, OCTBT_OE_N_RST}; // see R16
        end
        else
        begin
            a_drv_ff <= nxt_a_drv;
            b_drv_ff <= nxt_b_drv;
        end
    end

    assign a_bus_out = a_drv_ff.dout; // see R01
    assign a_bus_oe_n = a_drv_ff.oe_n;
    assign b_bus_out = b_drv_ff.dout;
    assign b_bus_oe_n = b_drv_ff.oe_n;

    // ====================================================================
    // Assertions
    sequence s_a_edge;
        cka_ff[1] && !cka_ff[2];
    endsequence
    sequence s_b_edge;
        ckb_ff[1] && !ckb_ff[2];
    endsequence

    property p_a_load;
        @(posedge ref_clk) disable iff (rst)
        s_a_edge |=> a_reg_ff == $past(a_live_ff);
    endproperty
    a_a_load: assert property (p_a_load) // see R03
        else $error("A register missed a capture edge");

    property p_hold;
        @(posedge ref_clk) disable iff (rst)
        (!cka_ff[1] || cka_ff[2]) |=> $stable(a_reg_ff);
    endproperty
    a_hold: assert property (p_hold) // see R15
        else $error("A register changed without a capture edge");

    // The B register must hold just as firmly between its own edges.
    property p_b_hold;
        @(posedge ref_clk) disable iff (rst)
        (!ckb_ff[1] || ckb_ff[2]) |=> $stable(b_reg_ff);
    endproperty
    a_b_hold: assert property (p_b_hold) // see R15
        else $error("B register changed without a capture edge");

    property p_both_load;
        @(posedge ref_clk) disable iff (rst)
        (s_a_edge and s_b_edge) |=> a_reg_ff == $past(a_live_ff)
            && b_reg_ff == $past(b_live_ff);
    endproperty
    a_both_load: assert property (p_both_load) // see R11
        else $error("Simultaneous edges did not load both registers");

    property p_b_oe;
        @(posedge ref_clk) disable iff (rst)
        $rose(a_to_b_drive_enable) ##1 a_to_b_drive_enable[*2]
            |=> !b_bus_oe_n;
    endproperty
    a_b_oe: assert property (p_b_oe) // see R04
        else $error("B side did not drive after its enable");

    property p_a_oe;
        @(posedge ref_clk) disable iff (rst)
        b_to_a_drive_enable_n[*3] |=> a_bus_oe_n;
    endproperty
    a_a_oe: assert property (p_a_oe) // see R04
        else $error("A side drove while its enable was high");

    property p_live_b_to_a;
        @(posedge ref_clk) disable iff (rst)
        (!oe_ab && !oe_ba_n && !sel_a) |=> !a_bus_oe_n && b_bus_oe_n
            && a_bus_out == $past(b_live_ff);
    endproperty
    a_live_b_to_a: assert property (p_live_b_to_a) // see R06
        else $error("A bus not fed from live B data");

    property p_stored_inv;
        @(posedge ref_clk) disable iff (rst)
        (!oe_ab && !oe_ba_n && sel_a) |=> a_bus_out == ~$past(b_reg_ff);
    endproperty
    a_stored_inv: assert property (p_stored_inv) // see R07
        else $error("A bus not fed from inverted B register");

    property p_live_a_to_b;
        @(posedge ref_clk) disable iff (rst)
        (oe_ab && oe_ba_n && !sel_b) |=> a_bus_oe_n && !b_bus_oe_n
            && b_bus_out == ~$past(a_live_ff);
    endproperty
    a_live_a_to_b: assert property (p_live_a_to_b) // see R08
        else $error("B bus not fed from inverted live A data");

    property p_stored_a;
        @(posedge ref_clk) disable iff (rst)
        (oe_ab && sel_b) |=> b_bus_out == $past(a_reg_ff);
    endproperty
    a_stored_a: assert property (p_stored_a) // see R09
        else $error("B bus not fed from A register");

    property p_both_stored;
        @(posedge ref_clk) disable iff (rst)
        (oe_ab && !oe_ba_n && sel_a && sel_b) |=> a_bus_out
            == $past(b_reg_ff) && b_bus_out == $past(a_reg_ff);
    endproperty
    a_both_stored: assert property (p_both_stored) // see R10
        else $error("Two-way stored transfer wrong");

    property p_reinforce;
        @(posedge ref_clk) disable iff (rst)
        reinforce |=> a_bus_out == $past(a_live_ff)
            && b_bus_out == $past(b_live_ff);
    endproperty
    a_reinforce: assert property (p_reinforce) // see R05
        else $error("Buses not holding their own level");

    property p_powerup;
        @(posedge ref_clk)
        rst |=> a_bus_oe_n && b_bus_oe_n;
    endproperty
    a_powerup: assert property (p_powerup) // see R16
        else $error("A or B bus driven right after reset");
endmodule // octbt_top

// [bench/octbt_bus_agent.sv]
// Bus agent model for the logic on the A and B buses of the transceiver.
// Assumes the bench says when the agent drives; it resolves both wires.
`timescale 1ns/1ps
module octbt_bus_agent
    import octbt_pkg::*;
(
    input wire logic ref_clk, // System clock.
    input wire logic a_en, // Agent drives the A bus.
    input wire logic [7:0] a_val, // Agent A data.
    input wire logic b_en, // Agent drives the B bus.
    input wire logic [7:0] b_val, // Agent B data.
    input wire octbt_drive_t a_dev, // Device drive on A.
    input wire octbt_drive_t b_dev, // Device drive on B.
    output logic [7:0] a_wire, // Resolved A level.
    output logic [7:0] b_wire // Resolved B level.
);
    // ====================================================================
    // Wire resolution
    logic [7:0] a_last_ff = 8'h00;
    logic [7:0] b_last_ff = 8'h00;

    // An undriven wire shows the inverse of its last level every cycle,
    // so logic that trusts a stale level is caught. The agent wins a
    // clash, which lets it overpower a bus held by the device.
    assign a_wire = a_en ? a_val : !a_dev.oe_n ? a_dev.dout : ~a_last_ff;
    assign b_wire = b_en ? b_val : !b_dev.oe_n ? b_dev.dout : ~b_last_ff;

    // Last levels seen on each bus.
    always_ff @(posedge ref_clk)
    begin
        a_last_ff <= a_wire;
        b_last_ff <= b_wire;
    end
endmodule // octbt_bus_agent

// [bench/testbench.sv]
// Self-checking bench for the octal bus transceiver.
// Assumes the bus agent model resolves both buses around the device.
`timescale 1ns/1ps
module testbench
    import octbt_pkg::*;
;
    // ====================================================================
    // Signals
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic a_en = 1'b0;
    logic b_en = 1'b0;
    logic [7:0] a_val = 8'h00;
    logic [7:0] b_val = 8'h00;
    logic a2b_en = 1'b0;
    logic b2a_en_n = 1'b1;
    logic sel_b = 1'b0;
    logic sel_a = 1'b0;
    logic cap_a = 1'b0;
    logic cap_b = 1'b0;
    logic [7:0] a_wire;
    logic [7:0] b_wire;
    octbt_drive_t a_dev;
    octbt_drive_t b_dev;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;

    octbt_top u_dut (
        .ref_clk(ref_clk), .rst(rst),
        .a_bus_in(a_wire), .a_bus_out(a_dev.dout), .a_bus_oe_n(a_dev.oe_n),
        .b_bus_in(b_wire), .b_bus_out(b_dev.dout), .b_bus_oe_n(b_dev.oe_n),
        .a_to_b_drive_enable(a2b_en), .b_to_a_drive_enable_n(b2a_en_n),
        .a_capture_clock(cap_a), .b_capture_clock(cap_b),
        .b_side_source_select(sel_b), .a_side_source_select(sel_a)
    );
    octbt_bus_agent u_agent (
        .ref_clk(ref_clk), .a_en(a_en), .a_val(a_val), .b_en(b_en),
        .b_val(b_val), .a_dev(a_dev), .b_dev(b_dev), .a_wire(a_wire),
        .b_wire(b_wire)
    );

    // Clock and timeout; the tests need about 160 cycles.
    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            n_mismatch++;
            stop_test();
        end
    end

    // ====================================================================
    // Access tasks; inputs move 1 ns after the edge, outputs settle by then.
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Mode is {a2b_en, b2a_en_n, sel_b, sel_a}; six cycles cover the lag.
    task automatic mode(input logic [3:0] m);
        {a2b_en, b2a_en_n, sel_b, sel_a} = m;
        tick(6);
    endtask
    task automatic agent(input logic [17:0] d);
        {a_en, a_val, b_en, b_val} = d;
        tick(6);
    endtask
    // Both capture clocks rise together, held three cycles each level.
    task automatic capture();
        {cap_a, cap_b} = 2'h3;
        tick(3);
        {cap_a, cap_b} = 2'h0;
        tick(3);
    endtask
    // Stored selects share a path, so the two rises come three cycles apart.
    task automatic capture_apart();
        cap_a = 1'b1;
        tick(3);
        cap_a = 1'b0;
        cap_b = 1'b1;
        tick(3);
        cap_b = 1'b0;
        tick(3);
    endtask
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ====================================================================
    // Tests
    initial
    begin
        tick(16);
        rst = 1'b0;
        tick(1);
        chk("a_oe_n", 8'h01, a_dev.oe_n);
        chk("b_oe_n", 8'h01, b_dev.oe_n);
        $display("test power_up done");
        agent({1'b1, 8'h3C, 1'b1, 8'hC5});
        capture();
        agent(18'h00000);
        mode(4'h7);
        chk("iso a_oe_n", 8'h01, a_dev.oe_n);
        chk("iso b_oe_n", 8'h01, b_dev.oe_n);
        mode(4'hE);
        chk("b stored", 8'h3C, b_dev.dout);
        chk("a_oe_n", 8'h01, a_dev.oe_n);
        chk("b_oe_n", 8'h00, b_dev.oe_n);
        mode(4'h1);
        chk("a stored inv", 8'h3A, a_dev.dout);
        chk("b_oe_n", 8'h01, b_dev.oe_n);
        mode(4'hB);
        chk("a both", 8'hC5, a_dev.dout);
        chk("b both", 8'h3C, b_dev.dout);
        $display("test stored done");
        mode(4'h0);
        agent({1'b0, 8'h00, 1'b1, 8'h96});
        chk("a live", 8'h96, a_dev.dout);
        capture();
        agent(18'h00000);
        mode(4'hB);
        chk("a reg", 8'h96, b_dev.dout);
        chk("b reg", 8'h96, a_dev.dout);
        agent({1'b1, 8'hA5, 1'b0, 8'h00});
        mode(4'hC);
        chk("b live inv", 8'h5A, b_dev.dout);
        capture();
        agent(18'h00000);
        mode(4'hB);
        chk("a reg", 8'hA5, b_dev.dout);
        chk("b reg", 8'h5A, a_dev.dout);
        $display("test live done");
        agent({1'b1, 8'hE1, 1'b1, 8'h1E});
        capture_apart();
        agent(18'h00000);
        chk("a reg apart", 8'hE1, b_dev.dout);
        chk("b reg apart", 8'h1E, a_dev.dout);
        $display("test stagger done");
        mode(4'h8);
        agent({1'b1, 8'hC3, 1'b1, 8'h3C});
        agent(18'h00000);
        chk("a held", 8'hC3, a_wire);
        chk("b held", 8'h3C, b_wire);
        $display("test reinforce done");
        stop_test();
    end
endmodule // testbench
